// file: hdl/ipsc_pkg.sv
/*
  Constants of the interrupt pending set/clear block: register offsets,
  reset values, source bit positions and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus and byte addressing.
*/
package ipsc_pkg;

  // Source count and bus widths
  localparam int IPSC_SRC_N = 17;
  localparam int IPSC_DATA_W = 32;
  localparam int IPSC_ADDR_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] IPSC_OFS_ENABLE_SET = 12'h100;
  localparam logic [11:0] IPSC_OFS_ENABLE_CLEAR = 12'h180;
  localparam logic [11:0] IPSC_OFS_PEND_SET = 12'h200;
  localparam logic [11:0] IPSC_OFS_PEND_CLEAR = 12'h280;
  localparam logic [11:0] IPSC_OFS_EVENT_STATUS = 12'h400;
  localparam logic [11:0] IPSC_OFS_EVENT_MASK = 12'h404;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] IPSC_RST_PEND = 32'h0000_0000;
  localparam logic [31:0] IPSC_RST_ENABLE = 32'h0000_0000;
  localparam logic [31:0] IPSC_RST_STATUS = 32'h0000_0000;
  localparam logic [31:0] IPSC_RST_MASK = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Source bit positions
  localparam int IPSC_BIT_TIMER_ONE = 0;
  localparam int IPSC_BIT_TIMER_TWO = 1;
  localparam int IPSC_BIT_MANAGEMENT = 2;
  localparam int IPSC_BIT_BASEBAND = 3;
  localparam int IPSC_BIT_SLEEP_TIMER = 4;
  localparam int IPSC_BIT_SERIAL_ONE = 5;
  localparam int IPSC_BIT_SERIAL_TWO = 6;
  localparam int IPSC_BIT_SECURITY = 7;
  localparam int IPSC_BIT_RADIO_TIMER = 8;
  localparam int IPSC_BIT_RADIO_TRANSMIT = 9;
  localparam int IPSC_BIT_RADIO_RECEIVE = 10;
  localparam int IPSC_BIT_ADC = 11;
  localparam int IPSC_BIT_EXT_LINE_A = 12;
  localparam int IPSC_BIT_EXT_LINE_B = 13;
  localparam int IPSC_BIT_EXT_LINE_C = 14;
  localparam int IPSC_BIT_EXT_LINE_D = 15;
  localparam int IPSC_BIT_DEBUG = 16;

  ////////////////////////////////////////////////////////////////////////////
  // AXI response codes
  localparam logic [1:0] IPSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPSC_RESP_SLVERR = 2'h2;

endpackage

// file: hdl/ipsc_top.sv
/*
  Pending-state part of a top-level interrupt controller: pending and
  enable bits per source, an AXI4-Lite register slave, and an event
  status/mask pair driving one interrupt line.
  Assumes sources and core acknowledges are synchronous to sys_clk.
*/
// The implementer's own choice: register access over AXI4-Lite.
// What this block does
// - Writing one to a pending-set bit makes that source pending.
// - Writing zero to pending-set or pending-clear bits changes nothing.
// - Writing one to a pending-clear bit removes that source's pending state, unless that source requests in the same cycle.
// - Bits 0..7: timers 1,2, management, baseband, sleep, serial 1,2, security.
// - Bits 8..16: radio timer, transmit, receive, ADC, lines A-D, debug.
// - After reset no source is pending; both registers read zero.
// - Pending-set decodes at 0x200, pending-clear at 0x280.
// - Enable-set register at 0x100 sets enable bits on ones only.
`timescale 1ns/1ps
`default_nettype none

module ipsc_top
  import ipsc_pkg::*;
#(
  parameter int SRC_N = IPSC_SRC_N,
  parameter int ADDR_W = IPSC_ADDR_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Interrupt sources and core side
  input wire logic [SRC_N-1:0] src_req,
  input wire logic [SRC_N-1:0] core_ack,
  output logic [SRC_N-1:0] core_pend,
  output logic irq,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  generate
    if (SRC_N <= IPSC_BIT_DEBUG || SRC_N > 31 || ADDR_W < 12 ||
        ADDR_W > 32) begin : g_bad_param
      $error("ipsc_top: unsupported SRC_N or ADDR_W");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [SRC_N-1:0] pend;
  logic [SRC_N-1:0] enable;
  logic [SRC_N-1:0] status;
  logic [SRC_N-1:0] mask;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [SRC_N-1:0] next_pend;
  logic [SRC_N-1:0] next_enable;
  logic [SRC_N-1:0] next_status;
  logic [SRC_N-1:0] next_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Write path decode
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire b_fire = s_axi_bvalid & s_axi_bready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire r_fire = s_axi_rvalid & s_axi_rready;
  // Both halves held and no response pending: perform the write
  wire do_wr = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire [11:0] wa = {aw_addr[11:2], 2'b00};
  wire sel_w_eset = (wa == IPSC_OFS_ENABLE_SET);
  wire sel_w_eclr = (wa == IPSC_OFS_ENABLE_CLEAR);
  wire sel_w_pset = (wa == IPSC_OFS_PEND_SET);
  wire sel_w_pclr = (wa == IPSC_OFS_PEND_CLEAR);
  wire sel_w_stat = (wa == IPSC_OFS_EVENT_STATUS);
  wire sel_w_mask = (wa == IPSC_OFS_EVENT_MASK);
  wire hi_zero_w = (ADDR_W == 12) ? 1'b1 : (aw_addr >> 12) == '0;
  wire w_mapped = hi_zero_w & (sel_w_eset | sel_w_eclr | sel_w_pset |
                               sel_w_pclr | sel_w_stat | sel_w_mask);
  wire [31:0] strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                           {8{w_strb[1]}}, {8{w_strb[0]}}};
  // Bits above the source count are dropped here
  wire [SRC_N-1:0] wr_bits = w_data[SRC_N-1:0] & strb_mask[SRC_N-1:0];
  wire [SRC_N-1:0] keep_mask = ~strb_mask[SRC_N-1:0];
  wire wr_ok = do_wr & hi_zero_w;
  wire [SRC_N-1:0] sw_pset = (wr_ok & sel_w_pset) ? wr_bits : '0;
  wire [SRC_N-1:0] sw_pclr = (wr_ok & sel_w_pclr) ? wr_bits : '0;
  wire [SRC_N-1:0] sw_eset = (wr_ok & sel_w_eset) ? wr_bits : '0;
  wire [SRC_N-1:0] sw_eclr = (wr_ok & sel_w_eclr) ? wr_bits : '0;
  wire [SRC_N-1:0] sw_sclr = (wr_ok & sel_w_stat) ? wr_bits : '0;
  wire mask_wr = wr_ok & sel_w_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Pending, enable and event logic
  // A source request is the same as a pending-set write; set beats clear
  wire [SRC_N-1:0] pend_set = src_req | sw_pset;
  wire [SRC_N-1:0] pend_clr = sw_pclr | core_ack;
  // Zero bits in either set or clear leave the bit alone
  assign next_pend = (pend & ~pend_clr) | pend_set;
  assign next_enable = (enable & ~sw_eclr) | sw_eset;
  wire [SRC_N-1:0] new_pend = next_pend & ~pend;
  assign next_status = (status & ~sw_sclr) | new_pend;
  assign next_mask = mask_wr ? ((mask & keep_mask) | wr_bits) : mask;
  wire irq_next = |(next_status & next_mask);
  wire [SRC_N-1:0] core_pend_next = next_pend & next_enable;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend <= IPSC_RST_PEND[SRC_N-1:0];
      enable <= IPSC_RST_ENABLE[SRC_N-1:0];
      status <= IPSC_RST_STATUS[SRC_N-1:0];
      mask <= IPSC_RST_MASK[SRC_N-1:0];
      irq <= 1'b0;
      core_pend <= '0;
    end else begin
      pend <= next_pend;
      enable <= next_enable;
      status <= next_status;
      mask <= next_mask;
      irq <= irq_next;
      core_pend <= core_pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI write channels
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IPSC_RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (aw_fire) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_mapped ? IPSC_RESP_OKAY : IPSC_RESP_SLVERR;
      end
      if (b_fire) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channels
  wire [11:0] ra = {s_axi_araddr[11:2], 2'b00};
  wire hi_zero_r = (ADDR_W == 12) ? 1'b1 : (s_axi_araddr >> 12) == '0;
  wire sel_r_en = hi_zero_r & ((ra == IPSC_OFS_ENABLE_SET) |
                               (ra == IPSC_OFS_ENABLE_CLEAR));
  wire sel_r_pend = hi_zero_r & ((ra == IPSC_OFS_PEND_SET) |
                                 (ra == IPSC_OFS_PEND_CLEAR));
  wire sel_r_stat = hi_zero_r & (ra == IPSC_OFS_EVENT_STATUS);
  wire sel_r_mask = hi_zero_r & (ra == IPSC_OFS_EVENT_MASK);
  wire r_mapped = sel_r_en | sel_r_pend | sel_r_stat | sel_r_mask;
  wire [SRC_N-1:0] r_bits = sel_r_pend ? pend :
                            sel_r_en ? enable :
                            sel_r_stat ? status :
                            sel_r_mask ? mask : '0;
  // Upper bits always read zero
  wire [31:0] r_word = {{(32-SRC_N){1'b0}}, r_bits};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= IPSC_RESP_OKAY;
    end else begin
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= r_word;
        s_axi_rresp <= r_mapped ? IPSC_RESP_OKAY : IPSC_RESP_SLVERR;
      end
      if (r_fire) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  logic seen_clk;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_pset_write;
    wr_ok && sel_w_pset;
  endsequence

  sequence s_pclr_write;
    wr_ok && sel_w_pclr;
  endsequence

  sequence s_pend_read;
    ar_fire && sel_r_pend;
  endsequence

  property p_pset_pends;
    s_pset_write |=> ((pend & $past(wr_bits)) == $past(wr_bits));
  endproperty
  a_pset_pends: assert property (p_pset_pends)
    else $error("pending-set write did not pend its sources");

  property p_zero_no_change;
    (wr_ok && (sel_w_pset || sel_w_pclr) && src_req == '0 &&
     core_ack == '0) |=> (((pend ^ $past(pend)) & ~$past(wr_bits)) == '0);
  endproperty
  a_zero_no_change: assert property (p_zero_no_change)
    else $error("zero bit in pending write changed a source");

  property p_pclr_unpends;
    (s_pclr_write ##0 ((src_req & wr_bits) == '0)) |=>
      ((pend & $past(wr_bits)) == '0);
  endproperty
  a_pclr_unpends: assert property (p_pclr_unpends)
    else $error("pending-clear write left a source pending");

  property p_timer_one_src;
    src_req[IPSC_BIT_TIMER_ONE] |=> pend[IPSC_BIT_TIMER_ONE] &&
      core_pend[IPSC_BIT_TIMER_ONE] == enable[IPSC_BIT_TIMER_ONE];
  endproperty
  a_timer_one_src: assert property (p_timer_one_src)
    else $error("timer one request not pending at bit 0");

  property p_debug_src;
    (src_req[IPSC_BIT_DEBUG] && !pend[IPSC_BIT_DEBUG]) |=>
      pend[IPSC_BIT_DEBUG] && status[IPSC_BIT_DEBUG];
  endproperty
  a_debug_src: assert property (p_debug_src)
    else $error("debug request not pending at bit 16");

  property p_reset_clear;
    !seen_clk |-> (pend == '0 && enable == '0 && !irq && !s_axi_bvalid);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not clear after reset");

  property p_pend_read;
    s_pend_read |=> s_axi_rvalid && s_axi_rresp == IPSC_RESP_OKAY &&
      s_axi_rdata[SRC_N-1:0] == $past(pend);
  endproperty
  a_pend_read: assert property (p_pend_read)
    else $error("pending read returned wrong data");

  property p_enable_set;
    (wr_ok && sel_w_eset) |=>
      ((enable & $past(wr_bits)) == $past(wr_bits)) &&
      ((~enable & $past(enable)) == '0);
  endproperty
  a_enable_set: assert property (p_enable_set)
    else $error("enable-set write misbehaved");

  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:SRC_N] == '0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data above source count not zero");

  property p_set_wins;
    (src_req[IPSC_BIT_ADC] && core_ack[IPSC_BIT_ADC]) |=>
      pend[IPSC_BIT_ADC];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat a simultaneous set");

  property p_irq_follows;
    irq == (|(status & mask));
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("irq low with unmasked status set");

  property p_write_resp;
    (aw_fire && w_fire && !s_axi_bvalid) |=> do_wr ##1
      (s_axi_bvalid [*1] ##0 !s_axi_awready);
  endproperty
  a_write_resp: assert property (p_write_resp)
    else $error("write response not raised two cycles after handshake");

  property p_read_unmapped;
    (ar_fire && !r_mapped) |=> s_axi_rvalid &&
      s_axi_rresp == IPSC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not refused");

  property p_status_clear;
    (wr_ok && sel_w_stat) |=>
      ((status & $past(wr_bits & ~new_pend)) == '0);
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status write-one-to-clear left a bit set");

  property p_busy_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("write channels ready while a response is pending");

  property p_ack_clears;
    (core_ack != '0 && src_req == '0 && !wr_ok) |=>
      ((pend & $past(core_ack)) == '0);
  endproperty
  a_ack_clears: assert property (p_ack_clears)
    else $error("core acknowledge left a source pending");

endmodule

`default_nettype wire

// file: verification/ipsc_far_model.sv
/*
  Far-side model: the peripheral interrupt sources and the core's
  acknowledge path. Assumes the bench calls its tasks and that
  sys_clk is the block's clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ipsc_far_model #(
  parameter int SRC_N = 17
) (
  // Clock
  input wire logic sys_clk,
  // Block side
  input wire logic [SRC_N-1:0] core_pend,
  output logic [SRC_N-1:0] src_req,
  output logic [SRC_N-1:0] core_ack
);
  initial begin
    src_req = '0;
    core_ack = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source requests held for a number of cycles, then dropped
  task automatic raise(input logic [SRC_N-1:0] m, input int cyc);
    @(posedge sys_clk);
    src_req <= m;
    repeat (cyc) @(posedge sys_clk);
    src_req <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Core takes what it sees pending, promptly or after a wait
  task automatic take(input int wait_cyc);
    repeat (wait_cyc) @(posedge sys_clk);
    core_ack <= core_pend;
    @(posedge sys_clk);
    core_ack <= '0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Fresh request in the very cycle the core acknowledges the same source
  task automatic collide(input logic [SRC_N-1:0] m);
    @(posedge sys_clk);
    src_req <= m;
    core_ack <= m;
    @(posedge sys_clk);
    src_req <= '0;
    core_ack <= '0;
  endtask
endmodule

`default_nettype wire

// file: verification/tb_top.sv
/*
  Self-checking bench of the pending set/clear block over AXI4-Lite.
  Assumes the far-side model drives sources and acknowledges.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ipsc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [16:0] src_req, core_ack, core_pend;
  logic irq, awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic [31:0] rdata;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  ipsc_top uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .src_req(src_req),
    .core_ack(core_ack), .core_pend(core_pend), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  ipsc_far_model far (
    .sys_clk(sys_clk), .core_pend(core_pend), .src_req(src_req),
    .core_ack(core_ack)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Write with both channels offered together, then wait for the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge sys_clk);
      if (!ad && awready === 1'b1) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(IPSC_OFS_PEND_SET, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_PEND_CLEAR, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_ENABLE_SET, 32'h0, IPSC_RESP_OKAY);
    $display("test reset done");
    // Each source position by request line and by software
    for (int i = 0; i < IPSC_SRC_N; i++) begin
      far.raise(17'h1 << i, 1);
      rd(IPSC_OFS_PEND_SET, 32'h1 << i, IPSC_RESP_OKAY);
      wr(IPSC_OFS_PEND_CLEAR, 32'h1 << i, IPSC_RESP_OKAY);
      rd(IPSC_OFS_PEND_SET, 32'h0, IPSC_RESP_OKAY);
      wr(IPSC_OFS_PEND_SET, 32'h1 << i, IPSC_RESP_OKAY);
      rd(IPSC_OFS_PEND_CLEAR, 32'h1 << i, IPSC_RESP_OKAY);
      wr(IPSC_OFS_PEND_CLEAR, 32'h1 << i, IPSC_RESP_OKAY);
    end
    $display("test source walk done");
    wr(IPSC_OFS_PEND_SET, 32'hFFFF_FFFF, IPSC_RESP_OKAY);
    rd(IPSC_OFS_PEND_SET, 32'h0001_FFFF, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_SET, 32'h0, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_PEND_CLEAR, 32'h0001_FFFF, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0000_5555, IPSC_RESP_OKAY);
    rd(IPSC_OFS_PEND_SET, 32'h0001_AAAA, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'hFFFF_FFFF, IPSC_RESP_OKAY);
    // Only the lowest byte lane is written
    wstrb <= 4'h1;
    wr(IPSC_OFS_PEND_SET, 32'h0001_0101, IPSC_RESP_OKAY);
    wstrb <= 4'hF;
    rd(IPSC_OFS_PEND_SET, 32'h0000_0001, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0000_0001, IPSC_RESP_OKAY);
    $display("test zero writes done");
    wr(IPSC_OFS_ENABLE_SET, 32'h0000_0009, IPSC_RESP_OKAY);
    wr(IPSC_OFS_ENABLE_SET, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_ENABLE_SET, 32'h0000_0009, IPSC_RESP_OKAY);
    far.raise(17'h0_000C, 2);
    @(posedge sys_clk);
    chk({15'h0, core_pend}, 32'h0000_0008);
    far.take(3);
    @(posedge sys_clk);
    chk({15'h0, core_pend}, 32'h0000_0000);
    rd(IPSC_OFS_PEND_SET, 32'h0000_0004, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0000_0004, IPSC_RESP_OKAY);
    wr(IPSC_OFS_ENABLE_CLEAR, 32'h0000_0001, IPSC_RESP_OKAY);
    rd(IPSC_OFS_ENABLE_CLEAR, 32'h0000_0008, IPSC_RESP_OKAY);
    far.collide(17'h0_0800);
    rd(IPSC_OFS_PEND_SET, 32'h0000_0800, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0000_0800, IPSC_RESP_OKAY);
    $display("test enable and core done");
    wr(12'h300, 32'h0000_0001, IPSC_RESP_SLVERR);
    rd(12'h300, 32'h0, IPSC_RESP_SLVERR);
    rd(IPSC_OFS_PEND_SET, 32'h0, IPSC_RESP_OKAY);
    $display("test unmapped done");
    wr(IPSC_OFS_EVENT_STATUS, 32'hFFFF_FFFF, IPSC_RESP_OKAY);
    wr(IPSC_OFS_EVENT_MASK, 32'h0000_0020, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_SET, 32'h0000_0020, IPSC_RESP_OKAY);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rd(IPSC_OFS_EVENT_STATUS, 32'h0000_0020, IPSC_RESP_OKAY);
    wr(IPSC_OFS_EVENT_STATUS, 32'h0000_0020, IPSC_RESP_OKAY);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    wr(IPSC_OFS_PEND_CLEAR, 32'h0000_0020, IPSC_RESP_OKAY);
    wr(IPSC_OFS_EVENT_MASK, 32'h0, IPSC_RESP_OKAY);
    wr(IPSC_OFS_PEND_SET, 32'h0000_0020, IPSC_RESP_OKAY);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    rd(IPSC_OFS_EVENT_STATUS, 32'h0000_0020, IPSC_RESP_OKAY);
    $display("test interrupt done");
    // Reset in mid-run with every source pending
    wr(IPSC_OFS_PEND_SET, 32'h0001_FFFF, IPSC_RESP_OKAY);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(IPSC_OFS_PEND_SET, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_PEND_CLEAR, 32'h0, IPSC_RESP_OKAY);
    rd(IPSC_OFS_ENABLE_SET, 32'h0, IPSC_RESP_OKAY);
    chk({15'h0, core_pend}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0);
    $display("test mid-run reset done");
    summarize();
  end
endmodule

`default_nettype wire
